// ===== hw/scs_startup.v
// start-up strap capture, shadow/active register commit and acquisition sequencing
`timescale 1ns/100ps
`include "scs_defines.vh"
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - after both supplies good, generate internal reset pulse of 8 clock cycles (75 ns rounded up to 80 ns), independent of pin.
// - within 45 ns of internal reset start, all eight pins are high-impedance inputs.
// - pins stay inputs during any reset; their levels are captured at reset release.
// - strap word bit n holds the level of multi-purpose pin n.
// - strap bits 2:0 zero select SPI, otherwise I2C with those address bits.
// - strap bits 7:3 zero keep defaults, otherwise start non-volatile load with that condition.
// - written settings take effect only after a one is written to update bit 0.
// - pins default to unassigned high-impedance inputs, configured at 0200 to 0207.
// - after reset interrupts are all masked and request output is open-drain.
// - watchdog disabled after reset, configured in 0200 space.
// - distribution output enables are disabled after reset.
// - manual profiles: after commit, lock to highest-priority available reference.
// - automatic profiles: detect register plus update start detection, then lock.
// - auto sync on lock makes clock appear at enabled outputs without host action.
// - otherwise a set-then-clear sync bit or sync pin pulse starts the outputs.
// - each pin is only ever an input, never driven; its role is set only by software.
module scs_startup
(
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire        supplyGood,
   input  wire [7:0]  pinIn,
   output reg  [7:0]  pinOut,
   output reg  [7:0]  pinOe_n,
   input  wire        wrEn,
   input  wire        rdEn,
   input  wire [15:0] regAddr,
   input  wire [7:0]  wrData,
   output reg  [7:0]  rdData,
   input  wire [7:0]  refAvail,
   input  wire        loopLocked,
   output reg  [7:0]  strapWord,
   output reg         portIsI2c,
   output reg  [2:0]  i2cAddrLow,
   output reg         nvLoadStart,
   output reg  [4:0]  nvLoadCond,
   output reg         calStart,
   output reg  [7:0]  detectRun,
   output reg  [2:0]  selectedRef,
   output reg         refSelValid,
   output reg  [7:0]  outEnable,
   output reg         outRun,
   output reg         irqOe_n,
   output reg         watchdogEn,
   output reg         intReset
);
////////////////////////////////////////////////////////////////////////////////
reg  [3:0]  porCnt_reg;
reg         supplySync1_reg;
reg         supplySync2_reg;
reg         porArmed_reg;
reg  [7:0]  pinSync1_reg;
reg  [7:0]  pinSync2_reg;
reg         inReset_reg;
reg  [7:0]  pinCfgSh_reg [0:7];
reg  [7:0]  pinCfg_reg   [0:7];
reg  [7:0]  irqSh_reg;
reg  [7:0]  irqCfg_reg;
reg  [7:0]  wdogSh_reg;
reg  [7:0]  outEnSh_reg;
reg  [7:0]  syncCalSh_reg;
reg  [7:0]  syncCal_reg;
reg  [7:0]  detectSh_reg;
reg  [7:0]  profSh_reg;
reg  [7:0]  prof_reg;
reg  [7:0]  syncModeSh_reg;
reg  [7:0]  syncMode_reg;
reg  [4:0]  detCnt_reg;
reg         detBusy_reg;
reg         acqArm_reg;
reg         syncPinPrev_reg;
wire        fullReset;
wire        commit;
wire        syncPin;
wire [2:0]  bestRef;
wire        anyRef;
integer     k;

// full-width counts, cut to the counter widths where they are loaded
localparam integer POR_LOAD = `SCS_POR_CYC - 1;
localparam integer DET_LOAD = `SCS_DETECT_CYC;

// priority pick over the eight refAvail bits: lower index is higher priority
function [3:0] pickRef;
   input [7:0] avail;
   integer i;
   begin
      pickRef = 4'h0;
      for (i = 7; i >= 0; i = i - 1)
         if (avail[i])
            pickRef = {1'b1, i[2:0]};
   end
endfunction

assign {anyRef, bestRef} = pickRef(refAvail);
assign fullReset = intReset | ~rst_n;
assign commit    = wrEn & (regAddr == `SCS_ADDR_UPDATE) & wrData[`SCS_BIT_UPDATE];

genvar g;
wire [7:0] syncSel;
generate
   for (g = 0; g < 8; g = g + 1)
   begin : gPin
      assign syncSel[g] = (pinCfg_reg[g] == `SCS_PINFN_SYNC) & pinSync2_reg[g];
   end
endgenerate
assign syncPin = |syncSel;

////////////////////////////////////////////////////////////////////////////////
// power-on pulse; counter only starts on supply good so it is independent of the pin
always @(posedge sys_clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      supplySync1_reg <= 1'b0;
      supplySync2_reg <= 1'b0;
      porCnt_reg      <= 4'h0;
      porArmed_reg    <= 1'b0;
      intReset        <= 1'b0;
   end
   else
   begin
      // supply monitor is asynchronous to sys_clk, so it is synchronised first
      supplySync1_reg <= supplyGood;
      supplySync2_reg <= supplySync1_reg;
      if (!porArmed_reg && supplySync2_reg)
      begin
         porArmed_reg <= 1'b1;
         intReset     <= 1'b1;
         porCnt_reg   <= POR_LOAD[3:0];
      end
      else if (intReset)
      begin
         if (porCnt_reg == 4'h0)
            intReset <= 1'b0;
         else
            porCnt_reg <= porCnt_reg - 4'h1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// pins pass two flops; strap captured once when both resets are gone
always @(posedge sys_clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      pinSync1_reg <= 8'h00;
      pinSync2_reg <= 8'h00;
      inReset_reg  <= 1'b0; // low, so only the end of the pulse captures
      strapWord    <= 8'h00;
      portIsI2c    <= 1'b0;
      i2cAddrLow   <= 3'h0;
      nvLoadStart  <= 1'b0;
      nvLoadCond   <= 5'h00;
   end
   else
   begin
      pinSync1_reg <= pinIn;
      pinSync2_reg <= pinSync1_reg;
      inReset_reg  <= intReset;
      nvLoadStart  <= 1'b0;
      if (inReset_reg && !intReset)
      begin
         strapWord   <= pinSync2_reg;
         portIsI2c   <= |pinSync2_reg[`SCS_PORT_LO:0];
         i2cAddrLow  <= pinSync2_reg[`SCS_PORT_LO:0];
         nvLoadStart <= |pinSync2_reg[`SCS_NV_HI:`SCS_NV_LO];
         nvLoadCond  <= pinSync2_reg[`SCS_NV_HI:`SCS_NV_LO];
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// shadow registers take writes; active copies load only on commit
always @(posedge sys_clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      for (k = 0; k < 8; k = k + 1)
      begin
         pinCfgSh_reg[k] <= 8'h00;
         pinCfg_reg[k]   <= 8'h00;
      end
      irqSh_reg      <= 8'h00;
      irqCfg_reg     <= 8'h00;
      wdogSh_reg     <= 8'h00;
      outEnSh_reg    <= 8'h00;
      syncCalSh_reg  <= 8'h00;
      syncCal_reg    <= 8'h00;
      detectSh_reg   <= 8'h00;
      profSh_reg     <= 8'h00;
      prof_reg       <= 8'h00;
      syncModeSh_reg <= 8'h00;
      syncMode_reg   <= 8'h00;
      watchdogEn     <= 1'b0;
      outEnable      <= 8'h00;
      irqOe_n        <= 1'b1;
   end
   else
   begin
      if (wrEn)
      begin
         if (regAddr >= `SCS_ADDR_PINCFG_LO && regAddr <= `SCS_ADDR_PINCFG_HI)
            pinCfgSh_reg[regAddr[2:0]] <= wrData;
         case (regAddr)
            `SCS_ADDR_IRQCFG:   irqSh_reg      <= wrData;
            `SCS_ADDR_WDOG:     wdogSh_reg     <= wrData;
            `SCS_ADDR_OUTEN:    outEnSh_reg    <= wrData;
            `SCS_ADDR_SYNCCAL:  syncCalSh_reg  <= wrData;
            `SCS_ADDR_DETECT:   detectSh_reg   <= wrData;
            `SCS_ADDR_PROFMODE: profSh_reg     <= wrData;
            `SCS_ADDR_SYNCMODE: syncModeSh_reg <= wrData;
            default:            ;
         endcase
      end
      if (commit)
      begin
         for (k = 0; k < 8; k = k + 1)
            pinCfg_reg[k] <= pinCfgSh_reg[k];
         irqCfg_reg   <= irqSh_reg;
         watchdogEn   <= wdogSh_reg[0];
         outEnable    <= outEnSh_reg;
         syncCal_reg  <= syncCalSh_reg;
         prof_reg     <= profSh_reg;
         syncMode_reg <= syncModeSh_reg;
      end
      // mask only moves once software commits a config; request output is always left released
      irqOe_n <= 1'b1;
   end
end

////////////////////////////////////////////////////////////////////////////////
// calibration, detection and sync sequencing
always @(posedge sys_clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      calStart        <= 1'b0;
      detectRun       <= 8'h00;
      detCnt_reg      <= 5'h00;
      detBusy_reg     <= 1'b0;
      acqArm_reg      <= 1'b0;
      selectedRef     <= 3'h0;
      refSelValid     <= 1'b0;
      outRun          <= 1'b0;
      syncPinPrev_reg <= 1'b0;
      pinOut          <= 8'h00;
      pinOe_n         <= 8'hff;
   end
   else
   begin
      calStart        <= commit & syncCalSh_reg[`SCS_BIT_CAL] & ~syncCal_reg[`SCS_BIT_CAL];
      syncPinPrev_reg <= syncPin;
      pinOut          <= 8'h00;
      pinOe_n         <= 8'hff;
      if (commit)
      begin
         if (profSh_reg[0] && detectSh_reg != 8'h00)
         begin
            detectRun   <= detectSh_reg;
            detBusy_reg <= 1'b1;
            detCnt_reg  <= DET_LOAD[4:0];
            acqArm_reg  <= 1'b0;
         end
         else if (!profSh_reg[0])
            acqArm_reg <= 1'b1;
      end
      else if (detBusy_reg)
      begin
         if (detCnt_reg == 5'h00)
         begin
            detBusy_reg <= 1'b0;
            detectRun   <= 8'h00;
            acqArm_reg  <= 1'b1;
         end
         else
            detCnt_reg <= detCnt_reg - 5'h01;
      end
      if (acqArm_reg && anyRef)
      begin
         selectedRef <= bestRef;
         refSelValid <= 1'b1;
      end
      if (syncMode_reg[0] && loopLocked)
         outRun <= 1'b1;
      else if (syncCal_reg[`SCS_BIT_SYNC] && commit && !syncCalSh_reg[`SCS_BIT_SYNC])
         outRun <= 1'b1;
      else if (syncPinPrev_reg && !syncPin)
         outRun <= 1'b1;
   end
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge sys_clk or negedge rst_n)
begin
   if (!rst_n)
      rdData <= 8'h00;
   else if (rdEn)
   begin
      case (regAddr)
         `SCS_ADDR_SYNCCAL:  rdData <= syncCalSh_reg;
         `SCS_ADDR_DETECT:   rdData <= detectSh_reg;
         `SCS_ADDR_IRQCFG:   rdData <= irqSh_reg;
         `SCS_ADDR_WDOG:     rdData <= wdogSh_reg;
         `SCS_ADDR_OUTEN:    rdData <= outEnSh_reg;
         `SCS_ADDR_PROFMODE: rdData <= profSh_reg;
         `SCS_ADDR_SYNCMODE: rdData <= syncModeSh_reg;
         `SCS_ADDR_STATUS:   rdData <= {outRun, refSelValid, detBusy_reg, portIsI2c, 1'b0, selectedRef};
         default:
            rdData <= (regAddr >= `SCS_ADDR_PINCFG_LO && regAddr <= `SCS_ADDR_PINCFG_HI) ?
                      pinCfgSh_reg[regAddr[2:0]] : 8'h00;
      endcase
   end
end

// fullReset only feeds an unused wire; the status register does not show it
wire unusedReset = fullReset & irqCfg_reg[0];

endmodule

// ===== hw/scs_defines.vh
// constants for the start-up strap and configuration sequencer
`ifndef SCS_DEFINES_VH
`define SCS_DEFINES_VH
`define SCS_POR_NS          75
`define SCS_CLK_NS          10
`define SCS_POR_CYC         ((`SCS_POR_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`define SCS_HIZ_NS          45
`define SCS_HIZ_CYC         (`SCS_HIZ_NS / `SCS_CLK_NS)
`define SCS_ADDR_UPDATE     16'h0005
`define SCS_ADDR_SYNCCAL    16'h0a02
`define SCS_ADDR_DETECT     16'h0a0d
`define SCS_ADDR_PINCFG_LO  16'h0200
`define SCS_ADDR_PINCFG_HI  16'h0207
`define SCS_ADDR_IRQCFG     16'h0208
`define SCS_ADDR_WDOG       16'h0209
`define SCS_ADDR_OUTEN      16'h0400
`define SCS_ADDR_PROFMODE   16'h0500
`define SCS_ADDR_SYNCMODE   16'h0401
`define SCS_ADDR_STATUS     16'h0d00
`define SCS_BIT_UPDATE      0
`define SCS_BIT_CAL         0
`define SCS_BIT_SYNC        1
`define SCS_PORT_LO         2
`define SCS_NV_LO           3
`define SCS_NV_HI           7
`define SCS_PINFN_SYNC      8'h01
`define SCS_DETECT_CYC      16
`endif

// ===== verification/scs_startup_properties.sv
// assertions for the start-up strap and commit sequencer
`timescale 1ns/100ps
module scs_startup_properties
(
   input logic        sys_clk,
   input logic        rst_n,
   input logic        wrEn,
   input logic [15:0] regAddr,
   input logic [7:0]  wrData,
   input logic [7:0]  pinOut,
   input logic [7:0]  pinOe_n,
   input logic [7:0]  strapWord,
   input logic        portIsI2c,
   input logic [2:0]  i2cAddrLow,
   input logic        nvLoadStart,
   input logic [4:0]  nvLoadCond,
   input logic        calStart,
   input logic [7:0]  detectRun,
   input logic [7:0]  outEnable,
   input logic        outRun,
   input logic        irqOe_n,
   input logic        watchdogEn,
   input logic        intReset
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire commitW = wrEn && regAddr == 16'h0005 && wrData[0];
   ////////////////////////////////////////////////////////////
   sequence s_por;
      intReset [*8] ##1 !intReset;
   endsequence
   sequence s_detect;
      (|detectRun) [*8] ##[9:10] !(|detectRun);
   endsequence
   a_por_width: assert property ($rose(intReset) |-> s_por)
      else $error("internal reset pulse length wrong");
   a_pins_input: assert property (pinOe_n == 8'hff && pinOut == 8'h00)
      else $error("multi-purpose pin driven");
   a_strap_held: assert property (!$past(intReset, 2) && !$past(intReset) |-> $stable(strapWord))
      else $error("strap word changed");
   a_port_select: assert property ($stable(strapWord) |-> portIsI2c == (strapWord[2:0] != 3'h0)
      && i2cAddrLow == strapWord[2:0]) else $error("port select mismatch");
   a_nv_cond: assert property (nvLoadStart |-> strapWord[7:3] != 5'h00 && nvLoadCond == strapWord[7:3])
      else $error("load condition mismatch");
   a_out_commit: assert property ($changed(outEnable) |-> $past(commitW))
      else $error("output enable moved without commit");
   a_cal_commit: assert property (calStart |-> $past(commitW))
      else $error("calibration start without commit");
   a_wdog_commit: assert property ($rose(watchdogEn) |-> $past(commitW))
      else $error("watchdog enabled without commit");
   a_irq_released: assert property (irqOe_n)
      else $error("request output driven");
   a_detect_len: assert property ($rose(|detectRun) |-> s_detect)
      else $error("detection length wrong");
   a_run_sticky: assert property (outRun |=> outRun)
      else $error("outputs stopped");
endmodule

// ===== verification/scs_pin_pulls.sv
// strap pull resistors on the multi-purpose pins
`timescale 1ns/100ps
module scs_pin_pulls
(
   input  logic [7:0] strapLevel,
   input  logic [7:0] pinOut,
   input  logic [7:0] pinOe_n,
   output logic [7:0] pinIn
);
   // pulls win wherever the device leaves a pin undriven
   assign pinIn = (pinOe_n & strapLevel) | (~pinOe_n & pinOut);
endmodule

// ===== verification/testbench.sv
// self-checking bench for the start-up strap and commit sequencer
`timescale 1ns/100ps
module testbench;
   logic        sys_clk, rst_n = 0, supplyGood = 0, wrEn = 0, rdEn = 0, loopLocked = 0;
   logic [15:0] regAddr = 0;
   logic [7:0]  wrData = 0, refAvail = 0, strapLevel = 0, rdData, pinIn, pinOut, pinOe_n, strapWord, detectRun;
   logic [7:0]  outEnable;
   logic [4:0]  nvLoadCond;
   logic [2:0]  i2cAddrLow, selectedRef;
   logic        portIsI2c, nvLoadStart, calStart, refSelValid, outRun, irqOe_n, watchdogEn, intReset;
   logic        calSeen = 0, nvSeen = 0;
   int          miscompares = 0, tests_run = 0, n;
   scs_startup scs_startup_i
   (
      .sys_clk     (sys_clk),
      .rst_n       (rst_n),
      .supplyGood  (supplyGood),
      .pinIn       (pinIn),
      .pinOut      (pinOut),
      .pinOe_n     (pinOe_n),
      .wrEn        (wrEn),
      .rdEn        (rdEn),
      .regAddr     (regAddr),
      .wrData      (wrData),
      .rdData      (rdData),
      .refAvail    (refAvail),
      .loopLocked  (loopLocked),
      .strapWord   (strapWord),
      .portIsI2c   (portIsI2c),
      .i2cAddrLow  (i2cAddrLow),
      .nvLoadStart (nvLoadStart),
      .nvLoadCond  (nvLoadCond),
      .calStart    (calStart),
      .detectRun   (detectRun),
      .selectedRef (selectedRef),
      .refSelValid (refSelValid),
      .outEnable   (outEnable),
      .outRun      (outRun),
      .irqOe_n     (irqOe_n),
      .watchdogEn  (watchdogEn),
      .intReset    (intReset)
   );
   scs_pin_pulls scs_pin_pulls_i
   (
      .strapLevel (strapLevel),
      .pinOut     (pinOut),
      .pinOe_n    (pinOe_n),
      .pinIn      (pinIn)
   );
   initial
   begin
      sys_clk = 0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      if (calStart === 1'b1) calSeen <= 1'b1;
      if (nvLoadStart === 1'b1) nvSeen <= 1'b1;
   end
   ////////////////////////////////////////////////////////////
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      if (miscompares == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task bound;
      if (n >= 60)
      begin
         miscompares++;
         end_sim;
      end
   endtask
   task tick;
      @(posedge sys_clk);
      #1;
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      wrEn <= 1'b1;
      regAddr <= a;
      wrData <= d;
      @(posedge sys_clk);
      wrEn <= 1'b0;
   endtask
   task rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      rdEn <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      rdEn <= 1'b0;
      #1 chk(rdData, exp);
   endtask
   ////////////////////////////////////////////////////////////
   task power_up(input logic [7:0] s);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      supplyGood <= 1'b0;
      strapLevel <= s;
      repeat (20) @(posedge sys_clk);
      nvSeen = 1'b0;
      rst_n <= 1'b1;
      @(posedge sys_clk);
      supplyGood <= 1'b1;
      for (n = 0; n < 60 && intReset !== 1'b1; n++) tick;
      bound;
      for (n = 0; n < 60 && intReset === 1'b1; n++) tick;
      bound;
      chk(n[7:0], 8'h08);
      repeat (4) tick;
      chk(strapWord, s);
      chk(portIsI2c, s[2:0] != 3'h0);
      chk(i2cAddrLow, s[2:0]);
      chk(nvSeen, s[7:3] != 5'h00);
      chk(nvLoadCond, s[7:3]);
      chk(pinOe_n, 8'hff);
      chk(outEnable, 8'h00);
      chk(watchdogEn, 1'b0);
      chk(irqOe_n, 1'b1);
   endtask
   task t_manual;
      power_up(8'h00);
      @(posedge sys_clk) refAvail <= 8'h30;
      wr(16'h0500, 8'h00);
      wr(16'h0005, 8'h01);
      repeat (4) tick;
      chk({refSelValid, selectedRef}, 8'h0c);
      wr(16'h0401, 8'h01);
      wr(16'h0005, 8'h01);
      tick;
      chk(outRun, 1'b0);
      @(posedge sys_clk) loopLocked <= 1'b1;
      repeat (3) tick;
      chk(outRun, 1'b1);
      @(posedge sys_clk) loopLocked <= 1'b0;
   endtask
   task t_i2c_hold;
      power_up(8'h2d);
      strapLevel <= 8'hd2;
      repeat (6) tick;
      chk({portIsI2c, i2cAddrLow}, 8'h0d);
      chk(strapWord, 8'h2d);
   endtask
   task t_commit;
      wr(16'h0100, 8'h0a);
      wr(16'h0005, 8'h01);
      wr(16'h0209, 8'h01);
      wr(16'h0400, 8'h05);
      tick;
      chk(outEnable, 8'h00);
      chk(watchdogEn, 1'b0);
      wr(16'h0005, 8'h01);
      tick;
      chk(outEnable, 8'h05);
      chk(watchdogEn, 1'b1);
      rd(16'h0400, 8'h05);
      rd(16'h0005, 8'h00);
      rd(16'h1234, 8'h00);
   endtask
   task t_cal_sync;
      calSeen = 1'b0;
      wr(16'h0a02, 8'h01);
      wr(16'h0005, 8'h01);
      wr(16'h0a02, 8'h00);
      wr(16'h0005, 8'h01);
      chk(calSeen, 1'b1);
      wr(16'h0a02, 8'h02);
      wr(16'h0005, 8'h01);
      tick;
      chk(outRun, 1'b0);
      wr(16'h0a02, 8'h00);
      wr(16'h0005, 8'h01);
      repeat (2) tick;
      chk(outRun, 1'b1);
   endtask
   task t_detect;
      wr(16'h0500, 8'h01);
      wr(16'h0a0d, 8'hff);
      wr(16'h0005, 8'h01);
      for (n = 0; n < 60 && detectRun === 8'h00; n++) tick;
      bound;
      chk(detectRun, 8'hff);
      @(posedge sys_clk) refAvail <= 8'h0c;
      for (n = 0; n < 60 && detectRun !== 8'h00; n++) tick;
      bound;
      chk(n >= 15 && n <= 17, 1'b1);
      chk({refSelValid, selectedRef}, 8'h0c);
      repeat (2) tick;
      chk({refSelValid, selectedRef}, 8'h0a);
   endtask
   task t_sync_pin;
      power_up(8'h01);
      wr(16'h0200, 8'h01);
      wr(16'h0005, 8'h01);
      repeat (4) tick;
      chk(outRun, 1'b0);
      rd(16'h0200, 8'h01);
      strapLevel <= 8'h00;
      repeat (4) tick;
      chk(outRun, 1'b1);
   endtask
   initial
   begin
      t_manual;
      t_i2c_hold;
      t_commit;
      t_cal_sync;
      t_detect;
      t_sync_pin;
      end_sim;
   end
endmodule
bind scs_startup scs_startup_properties scs_startup_properties_i
(
   .sys_clk     (sys_clk),
   .rst_n       (rst_n),
   .wrEn        (wrEn),
   .regAddr     (regAddr),
   .wrData      (wrData),
   .pinOut      (pinOut),
   .pinOe_n     (pinOe_n),
   .strapWord   (strapWord),
   .portIsI2c   (portIsI2c),
   .i2cAddrLow  (i2cAddrLow),
   .nvLoadStart (nvLoadStart),
   .nvLoadCond  (nvLoadCond),
   .calStart    (calStart),
   .detectRun   (detectRun),
   .outEnable   (outEnable),
   .outRun      (outRun),
   .irqOe_n     (irqOe_n),
   .watchdogEn  (watchdogEn),
   .intReset    (intReset)
);
